// ### logic/sct0_pkg.sv
package sct0_pkg;
  localparam logic [7:0] INS_UPDATE = 8'hd6;
  localparam logic [7:0] INS_SELECT = 8'ha4;
  localparam logic [7:0] INS_GETRSP = 8'hc0;
  localparam logic [7:0] INS_READ = 8'hb0;
  localparam logic [7:0] SW_OK1 = 8'h90;
  localparam logic [7:0] SW_OK2 = 8'h00;
  localparam logic [7:0] SW_MORE = 8'h61;
  localparam logic [7:0] SW_WRONGLEN = 8'h6c;
  localparam logic [7:0] SW_BADP1 = 8'h6b;
  localparam logic [7:0] SW_BADP2 = 8'h00;
  localparam logic [7:0] SW_NOREF1 = 8'h6a;
  localparam logic [7:0] SW_NOREF2 = 8'h86;
  localparam logic [7:0] SEL_P2 = 8'h04;
  localparam logic [7:0] SEL_LEN = 8'h02;
  localparam int RSP_DEPTH = 256;
  localparam int RSP_AW = 8;
  localparam logic [8:0] FULL_LEN = 9'h100;
  typedef enum logic [3:0] {
    SCT_IDLE = 4'b0000,
    SCT_HDR = 4'b0001,
    SCT_ACK = 4'b0010,
    SCT_BODY = 4'b0011,
    SCT_APP = 4'b0100,
    SCT_SEND = 4'b0101,
    SCT_SW1 = 4'b0110,
    SCT_SW2 = 4'b0111,
    SCT_LOAD = 4'b1000
  } sct_state_t;
endpackage : sct0_pkg

// ### logic/sct0_apdu.sv
`timescale 1ns/1ps
// Function
// RULE1: Update-binary header: echo instruction code as procedure byte before taking data.
// RULE2: Completed good case 3 body returns status 90 00.
// RULE3: Invalid second parameter: status 6B 00 or 6A 86 only, no data.
// RULE4: Terminal sends the data body once a procedure byte arrives.
// RULE5: Terminal sends no body when status replaces the procedure byte.
// RULE6: Good case 4 body returns 61 xx, xx the response length.
// RULE7: Failed case 4 body returns a warning or error status only.
// RULE8: Terminal follows 61 xx with get-response, length at most xx.
// RULE9: Warning or application status: terminal sends get-response with length 00.
// RULE10: Any other error: terminal drops the command.
// RULE11: Get-response is handled as a case 2 outgoing command.
// RULE12: Select with P2 04, length 2: echo A4, await two id bytes.
// RULE13: Get-response of full pending length: C0, all data, then 90 00.
// RULE14: Shorter get-response: leading bytes, then 61 with remaining count.
// RULE15: Le too large or 00 below 256 available: answer 6C with available length.
// RULE16: Le equal available, or 00 with 256: send all, then status.
// RULE17: Le below available: send that many, then 61 with remainder.
// RULE18: Abnormal case 2 processing never returns 90 00.
// RULE19: Pending response and remaining count survive until read or new command.
// RULE20: Terminal ends a case 3 command on any status.
module sct0_apdu (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  output logic appStart,
  output logic [7:0] appIns,
  output logic [7:0] appP1,
  output logic [7:0] appP2,
  output logic bodyValid,
  output logic [7:0] bodyByte,
  input wire logic appDone,
  input wire logic appOk,
  input wire logic [7:0] appSw1,
  input wire logic [7:0] appSw2,
  input wire logic rspValid,
  input wire logic [7:0] rspByte,
  output logic busy
);
  import sct0_pkg::*;

  typedef struct packed {
    sct_state_t st;
    logic [2:0] hdrCnt;
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    logic [8:0] cnt;
    logic [8:0] pend;
    logic [8:0] rdPtr;
    logic [8:0] wrPtr;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic txV;
    logic [7:0] txB;
    logic start;
    logic bodyV;
    logic [7:0] bodyB;
  } sct_regs_t;

  sct_regs_t r_q, r_d;
  logic [7:0] rspMem [RSP_DEPTH];
  logic memWe;
  logic [8:0] le;
  logic [7:0] memAddr;
  logic firstRsp;
  logic [8:0] pendLeft;

  // A header field of 00 asks for 256 bytes in outgoing direction
  function automatic logic [8:0] expand_len(input logic [7:0] v);
    expand_len = (v == 8'h00) ? FULL_LEN : {1'b0, v};
  endfunction : expand_len

  function automatic logic [7:0] low_len(input logic [8:0] v);
    low_len = v[7:0];
  endfunction : low_len

  // Holding register can take a byte when empty or when the link takes it now
  function automatic logic slot_free(input logic v, input logic rdy);
    slot_free = !v || rdy;
  endfunction : slot_free

  // Write commands never hand data back, whatever the application offers
  function automatic logic no_rsp(input logic [7:0] ins);
    no_rsp = (ins == INS_UPDATE);
  endfunction : no_rsp

  // Parameter check kept small: only second-parameter values and the select length this block knows
  function automatic logic p2_ok(input logic [7:0] ins, input logic [7:0] p2, input logic [7:0] p3);
    if (ins == INS_SELECT) p2_ok = (p2 == SEL_P2) && (p3 == SEL_LEN);
    else if (ins == INS_GETRSP) p2_ok = (p2 == 8'h00);
    else p2_ok = 1'b1;
  endfunction : p2_ok

  assign le = expand_len(r_q.p3);
  assign pendLeft = r_q.pend - le;
  // First response byte rides on the appDone cycle, so it lands before the load state
  assign firstRsp = (r_q.st == SCT_APP) && appDone && appOk && !no_rsp(r_q.ins);
  assign memAddr = (r_q.st == SCT_LOAD) ? r_q.wrPtr[7:0] : 8'h00;
  assign memWe = clkEn && rspValid && (firstRsp || (r_q.st == SCT_LOAD && r_q.wrPtr != FULL_LEN));

  always_comb begin
    r_d = r_q;
    r_d.start = 1'b0;
    r_d.bodyV = 1'b0;
    if (txReady) begin
      r_d.txV = 1'b0;
    end
    case (r_q.st)
      SCT_IDLE, SCT_HDR: begin
        if (rxValid) begin
          r_d.st = SCT_HDR;
          r_d.hdrCnt = r_q.hdrCnt + 3'd1;
          case (r_q.hdrCnt)
            3'd0: r_d.cla = rxByte;
            3'd1: r_d.ins = rxByte;
            3'd2: r_d.p1 = rxByte;
            3'd3: r_d.p2 = rxByte;
            default: r_d.p3 = rxByte;
          endcase
          if (r_q.hdrCnt == 3'd4) begin
            r_d.hdrCnt = 3'd0;
            r_d.st = SCT_ACK;
          end
        end
      end
      SCT_ACK: begin
        if (!p2_ok(r_q.ins, r_q.p2, r_q.p3)) begin
          r_d.sw1 = SW_BADP1; // see RULE3
          r_d.sw2 = SW_BADP2; // see RULE18
          r_d.st = SCT_SW1;
        end else if (r_q.ins == INS_GETRSP || r_q.ins == INS_READ) begin
          // Outgoing data: get-response treated as case 2, see RULE11
          if (r_q.ins == INS_READ) begin
            r_d.pend = 9'd0;
          end
          if (r_q.pend == 9'd0 || r_q.ins == INS_READ) begin
            r_d.sw1 = SW_NOREF1; // see RULE18
            r_d.sw2 = SW_NOREF2;
            r_d.st = SCT_SW1;
          end else if (le > r_q.pend) begin
            r_d.sw1 = SW_WRONGLEN; // see RULE15
            r_d.sw2 = low_len(r_q.pend);
            r_d.st = SCT_SW1;
          end else begin
            r_d.txV = 1'b1;
            r_d.txB = r_q.ins; // see RULE13
            r_d.cnt = le; // see RULE16
            r_d.st = SCT_SEND;
          end
        end else begin
          // Any other header brings a new command, so pending data dies
          r_d.pend = 9'd0; // see RULE19
          r_d.rdPtr = 9'd0;
          r_d.txV = 1'b1;
          r_d.txB = r_q.ins; // see RULE1
          r_d.cnt = {1'b0, r_q.p3}; // see RULE12
          r_d.start = 1'b1;
          r_d.st = (r_q.p3 == 8'h00) ? SCT_APP : SCT_BODY;
        end
        // Status takes the procedure byte's slot, so every answer starts alike
        if (r_d.st == SCT_SW1) begin
          r_d.txV = 1'b1;
          r_d.txB = r_d.sw1;
          r_d.st = SCT_SW2;
        end
      end
      SCT_BODY: begin
        if (rxValid) begin
          r_d.bodyV = 1'b1;
          r_d.bodyB = rxByte;
          r_d.cnt = r_q.cnt - 9'd1;
          if (r_q.cnt == 9'd1) begin
            r_d.st = SCT_APP;
          end
        end
      end
      SCT_APP: begin
        if (appDone) begin
          r_d.wrPtr = 9'd0;
          if (!appOk) begin
            r_d.sw1 = appSw1; // see RULE7
            r_d.sw2 = appSw2;
            r_d.st = SCT_SW1;
          end else if (no_rsp(r_q.ins) || !rspValid) begin
            r_d.sw1 = SW_OK1; // see RULE2
            r_d.sw2 = SW_OK2;
            r_d.st = SCT_SW1;
          end else begin
            r_d.wrPtr = 9'd1;
            r_d.st = SCT_LOAD;
          end
        end
      end
      SCT_LOAD: begin
        // Response bytes arrive back to back; first gap ends the response
        if (rspValid && r_q.wrPtr != FULL_LEN) begin
          r_d.wrPtr = r_q.wrPtr + 9'd1;
        end else begin
          r_d.pend = r_q.wrPtr;
          r_d.rdPtr = 9'd0;
          r_d.sw1 = SW_MORE; // see RULE6
          r_d.sw2 = low_len(r_q.wrPtr);
          r_d.st = SCT_SW1;
        end
      end
      SCT_SEND: begin
        if (slot_free(r_q.txV, txReady)) begin
          if (r_q.cnt == 9'd0) begin
            r_d.pend = pendLeft;
            if (r_q.pend == le) begin
              r_d.sw1 = SW_OK1; // see RULE13
              r_d.sw2 = SW_OK2;
            end else begin
              r_d.sw1 = SW_MORE; // see RULE14
              r_d.sw2 = low_len(pendLeft); // see RULE17
            end
            r_d.st = SCT_SW1;
          end else begin
            r_d.txV = 1'b1;
            r_d.txB = rspMem[r_q.rdPtr[7:0]];
            r_d.rdPtr = r_q.rdPtr + 9'd1; // see RULE19
            r_d.cnt = r_q.cnt - 9'd1;
          end
        end
      end
      SCT_SW1: begin
        if (slot_free(r_q.txV, txReady)) begin
          r_d.txV = 1'b1;
          r_d.txB = r_q.sw1;
          r_d.st = SCT_SW2;
        end
      end
      SCT_SW2: begin
        if (slot_free(r_q.txV, txReady)) begin
          r_d.txV = 1'b1;
          r_d.txB = r_q.sw2;
          r_d.st = SCT_IDLE;
        end
      end
      default: r_d.st = SCT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else if (clkEn) begin
      r_q <= r_d;
    end
  end

  // Memory left out of reset: contents only count from the read pointer for the pending length
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      rspMem[memAddr] <= rspByte;
    end
  end

  assign txValid = r_q.txV;
  assign txByte = r_q.txB;
  assign appStart = r_q.start;
  assign appIns = r_q.ins;
  assign appP1 = r_q.p1;
  assign appP2 = r_q.p2;
  assign bodyValid = r_q.bodyV;
  assign bodyByte = r_q.bodyB;
  assign busy = (r_q.st != SCT_IDLE) || r_q.txV;
endmodule : sct0_apdu

// ### test/sct0_term_model.sv
`timescale 1ns/1ps
module sct0_term_model (
  input wire logic clk_sys,
  output logic rxValid,
  output logic [7:0] rxByte,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  output logic txReady
);
  logic [7:0] got[$];
  initial {rxValid, rxByte, txReady} = 10'h000;
  // Random refusals show whether an offered byte stands
  always @(negedge clk_sys) txReady <= 1'($urandom_range(3) != 0);
  always @(posedge clk_sys) if (txValid && txReady) got.push_back(txByte);
  // Caller sends a body only after a procedure byte
  task automatic send(logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge clk_sys);
      {rxValid, rxByte} = {1'b1, b[i]};
    end
    @(negedge clk_sys);
    {rxValid, rxByte} = {1'b0, ~rxByte};
  endtask : send
endmodule : sct0_term_model

// ### test/sct0_apdu_asserts.sv
`timescale 1ns/1ps
module sct0_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  input wire logic txReady,
  input wire logic appStart,
  input wire logic [7:0] appIns,
  input wire logic bodyValid,
  input wire logic [7:0] bodyByte,
  input wire logic busy
);
  import sct0_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_hdr; !busy && rxValid ##1 rxValid [*4]; endsequence
  property p_ack; s_hdr |-> ##2 txValid; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_hold; txValid && !txReady |=> txValid && $stable(txByte); endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
  property p_idle; !busy |-> !txValid; endproperty
  a_idle: assert property (p_idle) else $error("idle tx");
  property p_quiet; !busy && !rxValid |=> !busy; endproperty
  a_quiet: assert property (p_quiet) else $error("idle left");
  property p_body; bodyValid |-> $past(rxValid) && bodyByte == $past(rxByte); endproperty
  a_body: assert property (p_body) else $error("bad body");
  property p_bodyq; bodyValid |-> busy && !txValid; endproperty
  a_bodyq: assert property (p_bodyq) else $error("body in tx");
  property p_end; $fell(busy) |-> $past(txValid && txReady); endproperty
  a_end: assert property (p_end) else $error("early end");
  property p_gr; appStart |-> appIns != INS_GETRSP; endproperty
  a_gr: assert property (p_gr) else $error("app got C0");
  property p_rst; $rose(nrst) |-> !txValid && !appStart && !bodyValid; endproperty
  a_rst: assert property (p_rst) else $error("reset out");
endmodule : sct0_asserts
bind sct0_apdu sct0_asserts u_chk (.*);

// ### test/sct0_tb.sv
`timescale 1ns/1ps
module tb;
  import sct0_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, clkEn = 1'b1, appDone = 1'b0, appOk = 1'b0, rspValid = 1'b0, ok;
  logic [7:0] appSw1 = 8'h00, appSw2 = 8'h00, rspByte = 8'h00, rxByte, txByte, appIns, appP1, appP2, bodyByte;
  logic rxValid, txValid, txReady, appStart, bodyValid, busy;
  logic [7:0] pend[$], ex[$], bq[$], d[$];
  int fail_count = 0, num_checks = 0, nr, ns;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (bodyValid) bq.push_back(bodyByte);
  always @(posedge clk_sys) if (appStart) ns++;
  sct0_apdu dut (.*);
  sct0_term_model term (.*);
  task automatic chk(string w, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic drain;
    for (int t = 0; t < 3000 && term.got.size() < ex.size(); t++) @(negedge clk_sys);
    foreach (ex[i]) chk("txByte", ex[i], i < term.got.size() ? term.got[i] : 8'hxx);
    term.got = {};
  endtask : drain
  task automatic cmd(logic [7:0] ins, p2, p3, int n = 0, logic k = 1'b1, logic [7:0] sw = 8'h00);
    int le = p3 == 8'h00 ? 256 : int'(p3);
    int starts = 0;
    ns = 0;
    term.send({8'h00, ins, 8'h00, p2, p3});
    if (ins == INS_READ) pend = {};
    if (ins == INS_GETRSP && p2 != 8'h00 || ins == INS_SELECT && (p2 != SEL_P2 || p3 != SEL_LEN)) begin
      ex = {SW_BADP1, SW_BADP2};
    end else if (ins inside {INS_GETRSP, INS_READ}) begin
      if (pend.size() == 0) ex = {SW_NOREF1, SW_NOREF2};
      else if (le > pend.size()) ex = {SW_WRONGLEN, 8'(pend.size())};
      else begin
        ex = {ins};
        repeat (le) ex.push_back(pend.pop_front());
        ex = {ex, pend.size() > 0 ? SW_MORE : SW_OK1, pend.size() > 0 ? 8'(pend.size()) : SW_OK2};
      end
    end else begin
      ex = {ins};
      drain();
      pend = {};
      bq = {};
      d = {};
      starts = 1;
      repeat (p3) d.push_back(8'($urandom));
      term.send(d);
      repeat (2) @(negedge clk_sys);
      foreach (d[i]) chk("bodyByte", d[i], i < bq.size() ? bq[i] : 8'hxx);
      chk("appIns", ins, appIns);
      chk("appP1", 8'h00, appP1);
      chk("appP2", p2, appP2);
      d = {};
      repeat (n) d.push_back(8'($urandom));
      {appDone, appOk, appSw1, appSw2} = {1'b1, k, sw, ~sw};
      for (int i = 0; i == 0 || i < n; i++) begin
        {rspValid, rspByte} = {i < n, i < n ? d[i] : 8'h00};
        @(negedge clk_sys);
        appDone = 1'b0;
      end
      {rspValid, rspByte} = {1'b0, ~rspByte};
      if (!k) ex = {sw, ~sw};
      else if (ins == INS_UPDATE || n == 0) ex = {SW_OK1, SW_OK2};
      else begin
        pend = d;
        ex = {SW_MORE, 8'(n)};
      end
    end
    drain();
    repeat (3) @(negedge clk_sys);
    chk("busy", 8'h00, {7'h00, busy});
    chk("appStart", 8'(starts), 8'(ns));
    chk("txExtra", 8'h00, 8'(term.got.size()));
  endtask : cmd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(44372));
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    cmd(INS_UPDATE, 8'h00, 8'h0b);
    cmd(INS_SELECT, 8'h01, SEL_LEN);
    cmd(INS_GETRSP, 8'h01, 8'h00);
    cmd(INS_SELECT, SEL_P2, SEL_LEN, 20);
    cmd(INS_GETRSP, 8'h00, 8'h07);
    cmd(INS_GETRSP, 8'h00, 8'h15);
    cmd(INS_GETRSP, 8'h00, 8'h0d);
    cmd(8'h88, 8'h00, 8'h01, 256);
    cmd(INS_GETRSP, 8'h00, 8'h00);
    cmd(INS_READ, 8'h00, 8'h0b);
    for (int i = 0; i < 4; i++) begin
      ok = 1'($urandom_range(1));
      nr = $urandom_range(9, 1);
      cmd(8'h20 + 8'(i), 8'h00, 8'h03, nr, ok, 8'h62 + 8'(i));
      if (ok || i < 2) cmd(INS_GETRSP, 8'h00, ok ? 8'(nr) : 8'h00);
    end
    cmd(8'h88, 8'h00, 8'h01, 5);
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    pend = {};
    cmd(INS_GETRSP, 8'h00, 8'h05);
    wrap_up();
  end
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule : tb
